// ==== pmp_port.v ====
// mac-facing mii / rmii / reverse mii data port with mode, drive limit and regulator select
// What this block does
// - MII moves 4-bit nibbles on its clocks
// - MII mode drives TXC and RXC 25 MHz
// - TXEN starts frames; RXDV marks received data
// - decode TXEN/TXER into idle, reserved, data, error
// - encode RXDV/RXER idle, false carrier, errors
// - RMII moves dibits on one 50 MHz clock
// - reference clock from crystal, oscillator, or PHY
// - RMII transmit: TXEN alone, no error code
// - reverse MII takes TXC and RXC as inputs
// - mode code 11 selects reverse MII
// - mode set by strap or management write
// - drive limit bit works in every mode
// - strap latched into regulator select at power-up
// - regulator select stays writable afterwards
`timescale 1ns/10ps
`include "pmp_consts.vh"
module pmp_port (
	// clock and reset
	input wire core_clk_i,
	input wire resetn_i,
	// straps
	input wire [1:0] mode_strap_i,
	input wire core_supply_strap_i,
	// management side
	input wire mode_wr_i,
	input wire [1:0] mode_wdata_i,
	input wire [1:0] ref_src_i,
	input wire drive_limit_wr_i,
	input wire drive_limit_wdata_i,
	input wire reg_src_wr_i,
	input wire reg_src_wdata_i,
	output wire [1:0] mode_o,
	output wire drive_limit_o,
	output wire core_reg_source_o,
	// transmit pins from the mac
	input wire [3:0] txd_i,
	input wire tx_en_i,
	input wire tx_er_i,
	// receive pins to the mac (rx_dv_o is crs_dv in rmii)
	output wire [3:0] rxd_o,
	output wire rx_dv_o,
	output wire rx_er_o,
	// transmit clock pin
	input wire txc_i,
	output wire txc_o,
	output wire txc_oe_n_o,
	// receive clock / reference clock pin
	input wire rxc_i,
	output wire rxc_o,
	output wire rxc_oe_n_o,
	// nibbles toward the line coder
	output wire [3:0] pcs_tx_data_o,
	output wire pcs_tx_strobe_o,
	output wire pcs_tx_err_o,
	output wire pcs_tx_reserved_o,
	// nibbles from the line decoder
	input wire [3:0] pcs_rx_data_i,
	input wire pcs_rx_strobe_i,
	input wire pcs_rx_dv_i,
	input wire pcs_rx_err_i,
	input wire pcs_rx_false_carrier_i
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg strap_done_reg; // straps taken once after reset release
	reg [1:0] mode_reg; // active interface mode
	reg drive_limit_reg; // reduced output drive
	reg core_reg_source_reg; // 0 internal regulator, 1 external supply
	reg [1:0] tx_lo_reg; // first dibit of an rmii transmit nibble
	reg tx_ph_reg; // rmii transmit dibit phase
	reg [3:0] pcs_tx_data_reg;
	reg pcs_tx_strobe_reg;
	reg pcs_tx_err_reg;
	reg pcs_tx_reserved_reg;
	reg [3:0] rx_nib_reg; // latest nibble from the decoder
	reg rx_dv_in_reg;
	reg rx_er_in_reg;
	reg rx_fc_in_reg;
	reg rx_ph_reg; // rmii receive dibit phase
	reg [3:0] rxd_reg;
	reg rx_dv_reg;
	reg rx_er_reg;
	reg txc_oe_n_reg;
	reg rxc_oe_n_reg;
	reg [3:0] rxd_next; // encoded receive pins
	reg rx_dv_next, rx_er_next;
	wire is_rmii, is_rev; // mode decodes
	wire rx_ext; // rx/ref clock taken from the pin
	wire tx_rise, rx_rise; // sampling instants
	wire tx_tick;
	// half periods in core cycles; only the low bits reach the three-bit divider
	localparam integer MII_HALF = `PMP_MII_HALF;
	localparam integer RMII_HALF = `PMP_RMII_HALF;

	assign is_rmii = (mode_reg == `PMP_MODE_RMII);
	assign is_rev = (mode_reg == `PMP_MODE_REV);
	// external 50 MHz oscillator feeds the pin in rmii; reverse mii takes both clocks in
	assign rx_ext = is_rev | (is_rmii & (ref_src_i == `PMP_REF_EXT50));

	// ----------------------------------------------------------------
	// interface clocks
	// ----------------------------------------------------------------
	// the 25 MHz transmit clock, or the pin in reverse mode
	pmp_clk_gen #(.CW(3)) u_txc (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.half_i(MII_HALF[2:0]),
		.ext_sel_i(is_rev),
		.ext_clk_i(txc_i),
		.clk_o(txc_o),
		.rise_o(tx_rise)
	);
	// the 25 MHz receive clock, or the 50 MHz reference clock in rmii
	pmp_clk_gen #(.CW(3)) u_rxc (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.half_i(is_rmii ? RMII_HALF[2:0] : MII_HALF[2:0]),
		.ext_sel_i(rx_ext),
		.ext_clk_i(rxc_i),
		.clk_o(rxc_o),
		.rise_o(rx_rise)
	);

	// rmii times both directions from the single reference clock
	assign tx_tick = is_rmii ? rx_rise : tx_rise;

	// ----------------------------------------------------------------
	// configuration: straps, mode, drive limit, regulator select
	// ----------------------------------------------------------------
	// straps are caught on the first edge after reset release, never by the reset itself
	always @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			strap_done_reg <= 1'b0;
			mode_reg <= `PMP_RST_MODE;
			drive_limit_reg <= `PMP_RST_DRIVE_LIMIT;
			core_reg_source_reg <= `PMP_RST_REG_SRC;
			{txc_oe_n_reg, rxc_oe_n_reg} <= 2'h3;
		end
		else
		begin
			strap_done_reg <= 1'b1;
			if (!strap_done_reg)
			begin
				mode_reg <= mode_strap_i;
				core_reg_source_reg <= core_supply_strap_i;
			end
			else
			begin
				// a mode change mid-frame cuts the frame; software should switch when idle
				if (mode_wr_i)
					mode_reg <= mode_wdata_i;
				if (reg_src_wr_i)
					core_reg_source_reg <= reg_src_wdata_i;
			end
			if (drive_limit_wr_i)
				drive_limit_reg <= drive_limit_wdata_i;
			// clock pins drive (enable low) once the straps are taken, unless the clock comes from outside
			txc_oe_n_reg <= ~strap_done_reg | is_rev;
			rxc_oe_n_reg <= ~strap_done_reg | rx_ext;
		end
	end

	// ----------------------------------------------------------------
	// transmit decode
	// ----------------------------------------------------------------
	// pins are sampled only on the rising edge of the active transmit clock
	always @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			{tx_lo_reg, tx_ph_reg} <= 3'h0;
			pcs_tx_data_reg <= 4'h0;
			{pcs_tx_strobe_reg, pcs_tx_err_reg, pcs_tx_reserved_reg} <= 3'h0;
		end
		else
		begin
			pcs_tx_strobe_reg <= 1'b0;
			if (tx_tick)
			begin
				if (is_rmii)
				begin
					// no error code in rmii; tx_er is ignored
					pcs_tx_err_reg <= 1'b0;
					pcs_tx_reserved_reg <= 1'b0;
					if (!tx_en_i)
						tx_ph_reg <= 1'b0;
					else if (!tx_ph_reg)
					begin
						// first dibit is the low half of the nibble
						tx_lo_reg <= txd_i[1:0];
						tx_ph_reg <= 1'b1;
					end
					else
					begin
						pcs_tx_data_reg <= {txd_i[1:0], tx_lo_reg};
						pcs_tx_strobe_reg <= 1'b1;
						tx_ph_reg <= 1'b0;
					end
				end
				else
				begin
					tx_ph_reg <= 1'b0;
					// reserved combination is reported and otherwise treated as idle
					pcs_tx_reserved_reg <= ~tx_en_i & tx_er_i;
					if (tx_en_i)
					begin
						pcs_tx_data_reg <= txd_i;
						pcs_tx_strobe_reg <= 1'b1;
						pcs_tx_err_reg <= tx_er_i;
					end
					else
						pcs_tx_err_reg <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// receive encode
	// ----------------------------------------------------------------
	// the decoder's latest nibble is held until the pins move on a clock rise
	always @*
	begin
		rxd_next = `PMP_NIB_IDLE;
		rx_dv_next = 1'b0;
		rx_er_next = 1'b0;
		if (rx_dv_in_reg)
		begin
			rx_dv_next = 1'b1;
			rx_er_next = rx_er_in_reg;
			if (is_rmii)
				rxd_next = {2'h0, rx_ph_reg ? rx_nib_reg[`PMP_DIBIT_HI] :
					rx_nib_reg[`PMP_DIBIT_LO]};
			else
				rxd_next = rx_nib_reg;
		end
		else if (rx_fc_in_reg && !is_rmii)
		begin
			// false carrier exists only in the mii code space
			rx_er_next = 1'b1;
			rxd_next = `PMP_NIB_FALSE_CARRIER;
		end
		// otherwise interframe: dv low, er low, data zero
	end

	// latch decoder output on its strobe and drive the pins on each receive clock rise
	always @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			{rx_nib_reg, rx_dv_in_reg, rx_er_in_reg, rx_fc_in_reg} <= 7'h00;
			rx_ph_reg <= 1'b0;
			{rxd_reg, rx_dv_reg, rx_er_reg} <= 6'h00;
		end
		else
		begin
			// a later decoder strobe overwrites one not yet shown on the pins
			if (pcs_rx_strobe_i)
				{rx_nib_reg, rx_dv_in_reg, rx_er_in_reg, rx_fc_in_reg} <=
					{pcs_rx_data_i, pcs_rx_dv_i, pcs_rx_err_i, pcs_rx_false_carrier_i};
			if (rx_rise)
			begin
				{rxd_reg, rx_dv_reg, rx_er_reg} <= {rxd_next, rx_dv_next, rx_er_next};
				// the dibit phase only advances inside a frame
				rx_ph_reg <= is_rmii & rx_dv_in_reg & ~rx_ph_reg;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign mode_o = mode_reg;
	assign drive_limit_o = drive_limit_reg;
	assign core_reg_source_o = core_reg_source_reg;
	assign rxd_o = rxd_reg;
	assign rx_dv_o = rx_dv_reg;
	assign rx_er_o = rx_er_reg;
	assign txc_oe_n_o = txc_oe_n_reg;
	assign rxc_oe_n_o = rxc_oe_n_reg;
	assign pcs_tx_data_o = pcs_tx_data_reg;
	assign pcs_tx_strobe_o = pcs_tx_strobe_reg;
	assign pcs_tx_err_o = pcs_tx_err_reg;
	assign pcs_tx_reserved_o = pcs_tx_reserved_reg;

endmodule // pmp_port

// ==== pmp_consts.vh ====
// constants of the media-independent data port: modes, clock timing, reset values
`ifndef PMP_CONSTS_VH
`define PMP_CONSTS_VH

// interface mode select codes
`define PMP_MODE_MII 2'h0
`define PMP_MODE_RMII 2'h1
`define PMP_MODE_SPARE 2'h2
`define PMP_MODE_REV 2'h3

// rmii reference clock source codes
`define PMP_REF_XTAL 2'h0
`define PMP_REF_EXT50 2'h1
`define PMP_REF_PHY25 2'h2

// clock periods in ns
`define PMP_CORE_CLK_NS 5
`define PMP_MII_CLK_NS 40
`define PMP_RMII_CLK_NS 20

// half-period counts in core cycles, derived from the periods
`define PMP_MII_HALF ((`PMP_MII_CLK_NS / `PMP_CORE_CLK_NS) / 2)
`define PMP_RMII_HALF ((`PMP_RMII_CLK_NS / `PMP_CORE_CLK_NS) / 2)

// receive line codes
`define PMP_NIB_IDLE 4'h0
`define PMP_NIB_FALSE_CARRIER 4'he

// field positions of a nibble split into dibits
`define PMP_DIBIT_LO 1:0
`define PMP_DIBIT_HI 3:2

// reset values
`define PMP_RST_MODE 2'h0
`define PMP_RST_REG_SRC 1'b0
`define PMP_RST_DRIVE_LIMIT 1'b0

`endif

// ==== pmp_clk_gen.v ====
// interface clock source: divided core clock or sampled external clock, with rise pulse
`timescale 1ns/10ps
module pmp_clk_gen #(
	parameter CW = 3
) (
	// clock and reset
	input wire core_clk_i,
	input wire resetn_i,
	// control
	input wire [CW-1:0] half_i,
	input wire ext_sel_i,
	input wire ext_clk_i,
	// results
	output wire clk_o,
	output wire rise_o
);

	reg [CW-1:0] cnt_reg; // cycles spent in the current half period
	reg clk_reg; // divided clock level
	reg ext_q_reg; // external clock sample
	reg ext_prev_reg; // previous external sample, for edge finding
	reg rise_reg; // one-cycle rising edge marker

	assign clk_o = clk_reg;
	assign rise_o = rise_reg;

	// ----------------------------------------------------------------
	// divider and edge detection
	// ----------------------------------------------------------------
	// the external pin is synchronous to the core clock, so one sample suffices
	always @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cnt_reg <= {CW{1'b0}};
			clk_reg <= 1'b0;
			ext_q_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			rise_reg <= 1'b0;
		end
		else
		begin
			ext_q_reg <= ext_clk_i;
			ext_prev_reg <= ext_q_reg;
			if (cnt_reg >= half_i - {{(CW-1){1'b0}}, 1'b1})
			begin
				// end of half period: flip the clock
				cnt_reg <= {CW{1'b0}};
				clk_reg <= ~clk_reg;
			end
			else
			begin
				cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
			end
			if (ext_sel_i)
				rise_reg <= ext_q_reg & ~ext_prev_reg;
			else
				rise_reg <= (cnt_reg >= half_i - {{(CW-1){1'b0}}, 1'b1}) & ~clk_reg;
		end
	end

endmodule // pmp_clk_gen

// ==== pmp_port_assertions.sv ====
// checker of the media-independent data port, bound to its top module
`timescale 1ns/10ps
module pmp_port_chk (
	// clock and reset
	input wire core_clk_i,
	input wire resetn_i,
	// management side
	input wire mode_wr_i,
	input wire [1:0] mode_wdata_i,
	input wire [1:0] ref_src_i,
	input wire [1:0] mode_o,
	// pins
	input wire [3:0] txd_i,
	input wire tx_en_i,
	input wire tx_er_i,
	input wire [3:0] rxd_o,
	input wire rx_dv_o,
	input wire rx_er_o,
	input wire txc_o,
	input wire txc_oe_n_o,
	input wire rxc_o,
	input wire rxc_oe_n_o,
	// toward the line coder
	input wire [3:0] pcs_tx_data_o,
	input wire pcs_tx_strobe_o,
	input wire pcs_tx_err_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	// cycles since reset or a mode write; a new mode needs time before its clocks settle
	logic [3:0] calm_reg;
	always @(posedge core_clk_i or negedge resetn_i)
		if (!resetn_i)
			calm_reg <= 4'h0;
		else if (mode_wr_i)
			calm_reg <= 4'h0;
		else if (calm_reg != 4'hf)
			calm_reg <= calm_reg + 4'h1;
	wire settled = calm_reg == 4'hf;
	a_mii_clk_period: assert property (disable iff (!resetn_i || mode_wr_i)
		settled && mode_o == 2'h0 && $rose(txc_o) |-> txc_o [*4] ##1 !txc_o [*4] ##1 txc_o)
		else $error("transmit clock period wrong");
	a_rmii_ref_period: assert property (disable iff (!resetn_i || mode_wr_i)
		settled && mode_o == 2'h1 && ref_src_i == 2'h0 && $rose(rxc_o) |->
		rxc_o [*2] ##1 !rxc_o [*2] ##1 rxc_o) else $error("reference clock period wrong");
	a_mii_clk_driven: assert property (
		settled && mode_o == 2'h0 |-> !txc_oe_n_o && !rxc_oe_n_o) else $error("clock pin released");
	a_tx_nibble_taken: assert property (
		settled && mode_o == 2'h0 && pcs_tx_strobe_o |-> $past(tx_en_i) &&
		pcs_tx_data_o == $past(txd_i) && pcs_tx_err_o == $past(tx_er_i))
		else $error("transmit nibble wrong");
	a_strobe_spacing: assert property (
		pcs_tx_strobe_o |=> !pcs_tx_strobe_o [*3]) else $error("strobes too close");
	a_mii_rx_codes: assert property (
		settled && mode_o == 2'h0 && rx_er_o && !rx_dv_o |-> rxd_o == 4'h0 || rxd_o == 4'he)
		else $error("reserved receive code");
	a_rmii_rx_codes: assert property (
		settled && mode_o == 2'h1 |-> rxd_o[3:2] == 2'h0 && (rx_dv_o || !rx_er_o || rxd_o == 4'h0))
		else $error("reserved rmii receive code");
	a_mode_write: assert property (
		mode_wr_i && calm_reg != 4'h0 |=> mode_o == $past(mode_wdata_i)) else $error("mode not written");
endmodule // pmp_port_chk
bind pmp_port pmp_port_chk chk (.*);

// ==== pmp_mac_model.sv ====
// mac model: drives the transmit pins on the interface clock and makes external clocks
`timescale 1ns/10ps
module pmp_mac_model (
	// clock and reset
	input wire core_clk_i,
	input wire resetn_i,
	// bench side: unit to send as {err, enable, nibble}
	input wire rmii_i,
	input wire [5:0] next_i,
	output logic took_o,
	// pin side
	input wire tclk_i,
	output logic [3:0] txd_o,
	output logic tx_en_o,
	output logic tx_er_o,
	output logic ck25_o,
	output logic ck50_o
);
	logic [2:0] div_reg; // free divider, runs like a board oscillator
	logic tclk_reg; // last seen interface clock level
	logic hi_reg; // upper dibit still to go
	logic [1:0] up_reg; // upper dibit kept for the second half
	assign ck50_o = div_reg[1];
	assign ck25_o = div_reg[2];
	// pins change only just after a rising interface clock, so the port samples them settled
	always @(posedge core_clk_i or negedge resetn_i)
		if (!resetn_i)
		begin
			{div_reg, tclk_reg, hi_reg, up_reg, took_o} <= 8'h00;
			{txd_o, tx_en_o, tx_er_o} <= 6'h00;
		end
		else
		begin
			div_reg <= div_reg + 3'h1;
			tclk_reg <= tclk_i;
			took_o <= 1'b0;
			if (tclk_i && !tclk_reg && hi_reg)
			begin
				txd_o <= {2'h0, up_reg};
				hi_reg <= 1'b0;
				took_o <= 1'b1;
			end
			else if (tclk_i && !tclk_reg)
			begin
				txd_o <= rmii_i ? {2'h0, next_i[1:0]} : next_i[3:0];
				up_reg <= next_i[3:2];
				{tx_er_o, tx_en_o} <= next_i[5:4];
				hi_reg <= rmii_i;
				took_o <= !rmii_i;
			end
		end
endmodule // pmp_mac_model

// ==== pmp_port_tb.sv ====
// bench of the media-independent data port with a mac model on its pins
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
	$display("wrong value at %0t: got %h want %h", $time, a, b); end end
module pmp_port_tb;
	logic core_clk_i = 0, resetn_i = 0, mode_wr_i = 0, drive_limit_wr_i = 0;
	logic drive_limit_wdata_i = 0, reg_src_wr_i = 0, reg_src_wdata_i = 0;
	logic [1:0] mode_strap_i = 0, mode_wdata_i = 0, ref_src_i = 0, mode_o;
	logic core_supply_strap_i = 1, pcs_rx_strobe_i = 0, pcs_rx_dv_i = 0;
	logic pcs_rx_err_i = 0, pcs_rx_false_carrier_i = 0, took, ck25, ck50;
	logic [3:0] pcs_rx_data_i = 0, txd_i, rxd_o, pcs_tx_data_o;
	logic tx_en_i, tx_er_i, rx_dv_o, rx_er_o, txc_i, txc_o, txc_oe_n_o, rxc_i, rxc_o;
	logic rxc_oe_n_o, drive_limit_o, core_reg_source_o, pcs_tx_strobe_o;
	logic pcs_tx_err_o, pcs_tx_reserved_o;
	logic [5:0] nxt = 0; // unit for the mac model: {err, enable, nibble}
	int n_errors = 0, check_count = 0, s;
	// pin levels: the far side drives a clock pin only while the port releases it
	assign txc_i = txc_oe_n_o ? ck25 : txc_o;
	assign rxc_i = rxc_oe_n_o ? (mode_o == 2'h1 ? ck50 : ck25) : rxc_o;
	initial forever #2.5 core_clk_i = ~core_clk_i;
	pmp_port uut (.*);
	pmp_mac_model mac (.core_clk_i, .resetn_i, .rmii_i(mode_o == 2'h1), .next_i(nxt),
		.took_o(took), .tclk_i(mode_o == 2'h1 ? rxc_i : txc_i), .txd_o(txd_i),
		.tx_en_o(tx_en_i), .tx_er_o(tx_er_i), .ck25_o(ck25), .ck50_o(ck50));
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	// wait, bounded, until the mac model launches a unit
	task automatic launch;
		for (int i = 0; i < 20 && took !== 1'b1; i++) cyc(1);
		cyc(1);
	endtask
	// send a unit; expect strobe s with error e, or else reserved flag r
	task automatic tx(input logic [5:0] v, input logic s, input logic e, input logic r);
		launch();
		nxt <= v;
		launch();
		for (int i = 0; i < 12 && pcs_tx_strobe_o !== 1'b1; i++) cyc(1);
		`CHK(pcs_tx_strobe_o, s)
		if (s) `CHK({pcs_tx_err_o, pcs_tx_data_o}, {e, v[3:0]})
		else `CHK(pcs_tx_reserved_o, r)
	endtask
	// one unit from the line decoder, v = {dv, err, false carrier, nibble}
	task automatic rx(input logic [6:0] v, input logic [5:0] e);
		pcs_rx_data_i <= v[3:0];
		{pcs_rx_dv_i, pcs_rx_err_i, pcs_rx_false_carrier_i} <= v[6:4];
		pcs_rx_strobe_i <= 1;
		cyc(1);
		pcs_rx_strobe_i <= 0;
		cyc(12);
		`CHK({rx_dv_o, rx_er_o, rxd_o}, e)
	endtask
	// the port cuts a frame on a mode change, so the mac model goes idle first
	task automatic wr_mode(input logic [1:0] m);
		nxt <= 6'h00;
		launch();
		launch();
		mode_wdata_i <= m;
		mode_wr_i <= 1;
		cyc(1);
		mode_wr_i <= 0;
		cyc(16);
		`CHK(mode_o, m)
	endtask
	task automatic wr_bits(input logic d, input logic r);
		{drive_limit_wdata_i, reg_src_wdata_i, drive_limit_wr_i, reg_src_wr_i} <= {d, r, 2'h3};
		cyc(1);
		{drive_limit_wr_i, reg_src_wr_i} <= 2'h0;
		cyc(2);
		`CHK({drive_limit_o, core_reg_source_o}, {d, r})
	endtask
	task automatic t_power_up;
		`CHK({mode_o, core_reg_source_o, drive_limit_o}, 4'h2)
		`CHK({txc_oe_n_o, rxc_oe_n_o}, 2'h0)
		wr_bits(1, 0);
		$display("power up test done");
	endtask
	task automatic t_mii;
		tx(6'h00, 0, 0, 0);
		tx(6'h2a, 0, 0, 1);
		tx(6'h15, 1, 0, 0);
		tx(6'h3c, 1, 1, 0);
		rx(7'h4a, 6'h2a);
		rx(7'h63, 6'h33);
		rx(7'h10, 6'h1e);
		$display("mii test done");
	endtask
	task automatic t_rmii;
		wr_mode(1);
		tx(6'h00, 0, 0, 0);
		tx(6'h36, 1, 0, 0);
		tx(6'h20, 0, 0, 0);
		rx(7'h45, 6'h21);
		rx(7'h6f, 6'h33);
		rx(7'h10, 6'h00);
		wr_bits(0, 1);
		$display("rmii test done");
	endtask
	task automatic t_ref_src;
		for (s = 1; s < 4; s++)
		begin
			wr_mode(0);
			ref_src_i <= s[1:0];
			wr_mode(1);
			`CHK(rxc_oe_n_o, s == 1)
			tx(6'h00, 0, 0, 0);
			tx(6'h19, 1, 0, 0);
		end
		wr_mode(0);
		ref_src_i <= 0;
		$display("reference clock test done");
	endtask
	// a second power-up in mid-run with the other strap values
	task automatic t_restrap;
		resetn_i <= 0;
		mode_strap_i <= 2'h1;
		core_supply_strap_i <= 0;
		cyc(2);
		resetn_i <= 1;
		cyc(4);
		`CHK({mode_o, core_reg_source_o, drive_limit_o}, 4'h4)
		tx(6'h19, 1, 0, 0);
		$display("strap test done");
	endtask
	task automatic t_reverse;
		wr_mode(2);
		tx(6'h15, 1, 0, 0);
		wr_mode(3);
		`CHK({txc_oe_n_o, rxc_oe_n_o}, 2'h3)
		tx(6'h00, 0, 0, 0);
		tx(6'h3c, 1, 1, 0);
		rx(7'h4a, 6'h2a);
		$display("reverse test done");
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		cyc(4);
		resetn_i <= 1;
		cyc(4);
		t_power_up();
		t_mii();
		t_rmii();
		t_ref_src();
		t_restrap();
		t_reverse();
		close_out();
	end
	// watchdog: the tests need about 4 us
	initial
	begin
		#60000;
		n_errors++;
		close_out();
	end
endmodule // pmp_port_tb
